/* core/adc_ctrl_regs.svh */
// Constants for the converter control sequencer: register map, fields, timing.
// Assumes inclusion by bare name from the package and the design modules.
//
// Contract
// - Power-on calibration starts after the delay picked by cal_delay_select.
// - Request high at power up skips auto calibration until a valid request.
// - calibration_active is high exactly while any calibration runs.
// - output_data_clock is frozen while calibration runs.
// - Calibration starts once request stays high the high-hold count after qualifying low.
// - Power-on calibration covers converter cores and input termination.
// - Full power-down high at power up holds the delay counter until low.
// - Extended control mode ignores delay select and uses the short delay.
// - Edge select high: data changes on rising clock edge; low: falling.
// - Swing select high gives strong drive, low gives low power drive.
// - Dual-edge mode routes one input to both converters on opposite edges; the code clears q_enable in that mode.
// - Pin mode: floating delay-select pin enters dual-edge on I, short delay.
// - Full power-down stops everything; Q power-down stops only Q channel.
// - Powered-down channel outputs are tristated; pipeline data invalid after wake.
// - Power-down waits for running calibration; requests while down are ignored.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// Byte address is four times the register index
`define DES_CTRL_INDEX    12'h00d
`define DES_CTRL_ADDR     (`DES_CTRL_INDEX * 12'h004)
`define CAL_CTRL_ADDR     12'h040
`define STATUS_ADDR       12'h044
`define DES_RESET         16'h0000
`define DES_ENABLE_BIT    15
`define DES_PHASE_BIT     14
`define DES_Q_INPUT_BIT   13
`define CAL_SW_REQ_BIT    0
`define CAL_EXT_MODE_BIT  1
`define CAL_HIGH_HOLD     32'd1280
`define CAL_LOW_HOLD      32'd1280
`define CAL_RUN_CYCLES    32'd4096
`define DELAY_SHORT       32'd4096
`define DELAY_LONG        32'd65536
`define PIN_SETTLE_CYCLES 32'd3

`endif

/* core/adc_ctrl_pkg.sv */
// Types shared by the converter control sequencer modules.
// Assumes the constants header sits beside it.
`include "adc_ctrl_regs.svh"

package adc_ctrl_pkg;

	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_DELAY,
		ST_IDLE,
		ST_CAL,
		ST_POWER_DOWN
	} seq_state_type;

	typedef struct packed {
		logic        i_enable;
		logic        q_enable;
		logic        i_data_oe;
		logic        q_data_oe;
		logic        dual_edge;
		logic        des_use_q;
		logic        strong_drive;
		logic        rising_edge_out;
		logic        output_data_clock;
		logic        cal_cores;
		logic        cal_termination;
	} analog_ctrl_type;

	typedef struct packed {
		logic        req_seen;
		logic        low_ok;
		logic [31:0] run_count;
		logic        last_level;
	} req_filter_type;

endpackage

/* core/cal_request_filter.sv */
// Debounce of the calibrate request pin: counts low and high runs.
// Assumes the pin input is already synchronised to pclk.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module cal_request_filter #(
	parameter logic [31:0] LOW_HOLD  = `CAL_LOW_HOLD,
	parameter logic [31:0] HIGH_HOLD = `CAL_HIGH_HOLD
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic level,
	output logic      request
);

	adc_ctrl_pkg::req_filter_type state_reg;
	adc_ctrl_pkg::req_filter_type state_next;

	always_comb begin
		state_next            = state_reg;
		state_next.req_seen   = 1'b0;
		state_next.last_level = level;
		if (level != state_reg.last_level) begin
			// Run restarts on every change; a high run keeps the low qualification
			state_next.run_count = 32'h0000_0001;
			if (level)
				state_next.low_ok = (state_reg.run_count >= LOW_HOLD);
			else
				state_next.low_ok = 1'b0;
		end else if (state_reg.run_count != 32'hFFFF_FFFF) begin
			state_next.run_count = state_reg.run_count + 32'h0000_0001;
		end
		if (level && state_reg.low_ok && state_next.run_count == HIGH_HOLD) begin
			state_next.req_seen = 1'b1;
			state_next.low_ok   = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= '{req_seen: 1'b0, low_ok: 1'b0,
				run_count: 32'h0000_0000, last_level: 1'b0};
		else if (clk_en)
			state_reg <= state_next;
	end

	assign request = state_reg.req_seen;

endmodule

/* core/adc_control_pin_sequencer.sv */
// Control sequencer: calibration timing, power down, output and dual-edge setup.
// Assumes pins arrive asynchronously and APB runs on pclk.
// Pins are level inputs from another domain; nothing here is edge triggered.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module adc_control_pin_sequencer #(
	parameter logic [31:0] DELAY_SHORT = `DELAY_SHORT,
	parameter logic [31:0] DELAY_LONG  = `DELAY_LONG,
	parameter logic [31:0] CAL_CYCLES  = `CAL_RUN_CYCLES,
	parameter logic [31:0] LOW_HOLD    = `CAL_LOW_HOLD,
	parameter logic [31:0] HIGH_HOLD   = `CAL_HIGH_HOLD
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      clk_en,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      cal_request_pin,
	input  wire logic                      cal_delay_select,
	input  wire logic                      delay_pin_floating,
	input  wire logic                      output_edge_select,
	input  wire logic                      output_swing_select,
	input  wire logic                      full_power_down,
	input  wire logic                      q_channel_power_down,
	output logic                           calibration_active,
	output adc_ctrl_pkg::analog_ctrl_type  analog_ctrl
);

	// ==========================================
	// State
	typedef struct packed {
		// Three-stage pin synchronisers, newest bit lowest
		logic [2:0]                  s_req;
		logic [2:0]                  s_dly;
		logic [2:0]                  s_flt;
		logic [2:0]                  s_edge;
		logic [2:0]                  s_swing;
		logic [2:0]                  s_pd;
		logic [2:0]                  s_pdq;
		adc_ctrl_pkg::seq_state_type seq;
		logic [31:0]                 count;
		logic                        power_on_cal;
		// Register file
		logic [15:0]                 des_ctrl;
		logic                        ext_mode;
		logic                        sw_req;
		logic                        clk_div;
		// Bus answer
		logic [31:0]                 prdata;
		logic                        pready;
		logic                        pslverr;
		logic                        cal_active;
		adc_ctrl_pkg::analog_ctrl_type ctrl;
	} core_state_type;

	core_state_type state_reg;
	core_state_type state_next;
	logic           pin_request;

	// ==========================================
	// Pin synchronisers and decode
	// Debounced level: second and third stages agree
	function automatic logic settled(input logic [2:0] s, input logic prev);
		settled = (s[1] == s[2]) ? s[2] : prev;
	endfunction

	// One select bit per register, shared by the answer and the writes
	function automatic logic [2:0] decode(input logic [11:0] a);
		decode = {a == `STATUS_ADDR, a == `CAL_CTRL_ADDR, a == `DES_CTRL_ADDR};
	endfunction

	logic req_level;
	logic pd_level;
	logic pdq_level;
	logic dly_level;
	logic flt_level;
	logic edge_level;
	logic swing_level;
	logic req_level_reg;
	logic pd_level_reg;
	logic pdq_level_reg;
	logic dly_level_reg;
	logic flt_level_reg;
	logic edge_level_reg;
	logic swing_level_reg;

	// Agreed levels feed all logic; the raw stages are read only here
	assign req_level   = settled(state_reg.s_req, req_level_reg);
	assign pd_level    = settled(state_reg.s_pd, pd_level_reg);
	assign pdq_level   = settled(state_reg.s_pdq, pdq_level_reg);
	assign dly_level   = settled(state_reg.s_dly, dly_level_reg);
	assign flt_level   = settled(state_reg.s_flt, flt_level_reg);
	assign edge_level  = settled(state_reg.s_edge, edge_level_reg);
	assign swing_level = settled(state_reg.s_swing, swing_level_reg);

	// Last agreed level; a disagreement keeps it, so one-cycle glitches never pass but two-cycle pulses do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_level_reg   <= 1'b0;
			pd_level_reg    <= 1'b0;
			pdq_level_reg   <= 1'b0;
			dly_level_reg   <= 1'b0;
			flt_level_reg   <= 1'b0;
			edge_level_reg  <= 1'b0;
			swing_level_reg <= 1'b0;
		end else if (clk_en) begin
			req_level_reg   <= req_level;
			pd_level_reg    <= pd_level;
			pdq_level_reg   <= pdq_level;
			dly_level_reg   <= dly_level;
			flt_level_reg   <= flt_level;
			edge_level_reg  <= edge_level;
			swing_level_reg <= swing_level;
		end
	end

	// Filter sees the agreed level, so its counts are pin cycles after sync
	cal_request_filter #(
		.LOW_HOLD  (LOW_HOLD),
		.HIGH_HOLD (HIGH_HOLD)
	) u_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.level   (req_level),
		.request (pin_request)
	);

	// ==========================================
	// Sequencer and register file
	logic        des_mode;
	logic        pin_des;
	logic [31:0] delay_target;
	logic        apb_access;
	logic        addr_ok;
	logic [2:0]  reg_sel;
	logic        sw_set;
	logic        pd_hold;

	always_comb begin
		// Floating delay pin only counts in pin mode
		pin_des      = !state_reg.ext_mode && flt_level;
		des_mode     = state_reg.ext_mode ? state_reg.des_ctrl[`DES_ENABLE_BIT] : pin_des;
		// Extended mode has no pin choice, only the short delay
		if (state_reg.ext_mode || pin_des)
			delay_target = DELAY_SHORT;
		else
			delay_target = dly_level ? DELAY_LONG : DELAY_SHORT;
		// Access phase is taken once; the registered answer blocks a repeat
		apb_access   = psel && penable && !state_reg.pready;
		reg_sel      = decode(paddr);
		addr_ok      = |reg_sel;
		// Software request seen here so a clear in the same cycle loses
		sw_set       = apb_access && pwrite && reg_sel[1] && pwdata[`CAL_SW_REQ_BIT];
	end

	always_comb begin
		state_next         = state_reg;
		state_next.s_req   = {state_reg.s_req[1:0], cal_request_pin};
		state_next.s_dly   = {state_reg.s_dly[1:0], cal_delay_select};
		state_next.s_flt   = {state_reg.s_flt[1:0], delay_pin_floating};
		state_next.s_edge  = {state_reg.s_edge[1:0], output_edge_select};
		state_next.s_swing = {state_reg.s_swing[1:0], output_swing_select};
		state_next.s_pd    = {state_reg.s_pd[1:0], full_power_down};
		state_next.s_pdq   = {state_reg.s_pdq[1:0], q_channel_power_down};
		state_next.pready  = 1'b0;
		state_next.pslverr = 1'b0;

		// One wait state, then answer; unmapped addresses give an error
		if (apb_access) begin
			state_next.pready  = 1'b1;
			state_next.pslverr = !addr_ok;
			state_next.prdata  = 32'h0000_0000;
			if (pwrite) begin
				if (reg_sel[0])
					state_next.des_ctrl = pwdata[15:0];
				// Extended mode bit and a sticky software request
				if (reg_sel[1]) begin
					state_next.ext_mode = pwdata[`CAL_EXT_MODE_BIT];
					state_next.sw_req   = state_reg.sw_req | pwdata[`CAL_SW_REQ_BIT];
				end
			end else begin
				// Status shows the raw sequencer state; unmapped reads give zero
				case (paddr)
					`DES_CTRL_ADDR: state_next.prdata = {16'h0000, state_reg.des_ctrl};
					`CAL_CTRL_ADDR: state_next.prdata = {30'h0, state_reg.ext_mode,
						state_reg.sw_req};
					`STATUS_ADDR:   state_next.prdata = {29'h0, state_reg.seq};
					default:        state_next.prdata = 32'h0000_0000;
				endcase
			end
		end

		case (state_reg.seq)
			adc_ctrl_pkg::ST_POWERUP: begin
				// Wait for the synchronisers to fill: before that a high pin reads low
				if (state_reg.count < `PIN_SETTLE_CYCLES) begin
					state_next.count = state_reg.count + 32'h0000_0001;
				end else begin
					// Request pin high at power up skips the automatic run
					state_next.count = 32'h0000_0000;
					if (req_level)
						state_next.seq = adc_ctrl_pkg::ST_IDLE;
					else
						state_next.seq = adc_ctrl_pkg::ST_DELAY;
				end
			end
			adc_ctrl_pkg::ST_DELAY: begin
				// Counter stalls while power-down is held, postponing the first run
				if (!pd_level) begin
					state_next.count = state_reg.count + 32'h0000_0001;
					if (state_next.count >= delay_target) begin
						state_next.seq          = adc_ctrl_pkg::ST_CAL;
						state_next.count        = 32'h0000_0000;
						state_next.power_on_cal = 1'b1;
					end
				end
			end
			adc_ctrl_pkg::ST_IDLE: begin
				state_next.count = 32'h0000_0000;
				if (pd_level) begin
					// Power down wins over a pending request
					state_next.seq = adc_ctrl_pkg::ST_POWER_DOWN;
				end else if (pin_request || state_reg.sw_req) begin
					state_next.seq          = adc_ctrl_pkg::ST_CAL;
					state_next.power_on_cal = 1'b0;
					// A request written in this very cycle stays armed
					state_next.sw_req       = sw_set;
				end
			end
			adc_ctrl_pkg::ST_CAL: begin
				// Power down waits here until the run finishes
				state_next.count = state_reg.count + 32'h0000_0001;
				if (state_next.count >= CAL_CYCLES) begin
					state_next.count = 32'h0000_0000;
					state_next.seq   = pd_level ? adc_ctrl_pkg::ST_POWER_DOWN
						: adc_ctrl_pkg::ST_IDLE;
				end
			end
			adc_ctrl_pkg::ST_POWER_DOWN: begin
				// Requests arriving while down are dropped
				state_next.sw_req = 1'b0;
				if (!pd_level)
					state_next.seq = adc_ctrl_pkg::ST_IDLE;
			end
			default: state_next.seq = adc_ctrl_pkg::ST_IDLE;
		endcase

		state_next.cal_active = (state_next.seq == adc_ctrl_pkg::ST_CAL);
		// Data clock runs only in idle, so receivers see it stop in calibration
		state_next.clk_div    = state_reg.clk_div ^ (state_next.seq == adc_ctrl_pkg::ST_IDLE);

		// A held power-down keeps the converters off before the first run too
		pd_hold = pd_level && (state_next.seq == adc_ctrl_pkg::ST_POWERUP
			|| state_next.seq == adc_ctrl_pkg::ST_DELAY);
		state_next.ctrl.i_enable        = state_next.seq != adc_ctrl_pkg::ST_POWER_DOWN
			&& !pd_hold;
		state_next.ctrl.q_enable        = state_next.ctrl.i_enable && !pdq_level
			&& !des_mode;
		state_next.ctrl.i_data_oe       = state_next.ctrl.i_enable;
		state_next.ctrl.q_data_oe       = state_next.ctrl.i_enable && !pdq_level;
		state_next.ctrl.dual_edge       = des_mode;
		state_next.ctrl.des_use_q       = state_reg.ext_mode
			&& state_reg.des_ctrl[`DES_Q_INPUT_BIT];
		state_next.ctrl.strong_drive    = swing_level;
		state_next.ctrl.rising_edge_out = edge_level;
		state_next.ctrl.output_data_clock = state_next.clk_div;
		state_next.ctrl.cal_cores       = state_next.cal_active;
		state_next.ctrl.cal_termination = state_next.cal_active
			&& state_next.power_on_cal;

		// Freeze applied last so every field holds, the bus answer included
		if (!clk_en)
			state_next = state_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Pin history starts low, the idle level of every pin
			state_reg          <= '0;
			state_reg.seq      <= adc_ctrl_pkg::ST_POWERUP;
			state_reg.des_ctrl <= `DES_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Outputs, all straight from the state register
	assign prdata             = state_reg.prdata;
	assign pready             = state_reg.pready;
	assign pslverr            = state_reg.pslverr;
	assign calibration_active = state_reg.cal_active;
	assign analog_ctrl        = state_reg.ctrl;

endmodule

/* verif/seq_ctrl_chk.sv */
// Checker on the sequencer ports: bus answer, calibration run, power down.
// Assumes the bind at the foot of this file; clk_en mostly high.
`timescale 1ns/1ps
module seq_ctrl_chk #(
	parameter logic [31:0] CAL_CYCLES = 32'h0000_0014
) (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	clk_en,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic [11:0]	paddr,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	output_edge_select,
	input wire logic	output_swing_select,
	input wire logic	full_power_down,
	input wire logic	q_channel_power_down,
	input wire logic	calibration_active,
	input wire adc_ctrl_pkg::analog_ctrl_type	analog_ctrl
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [31:0]	len_reg;
	// ==========
	// Run length; frozen cycles do not count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_reg <= 32'h0000_0000;
		end else if (!calibration_active) begin
			len_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			len_reg <= len_reg + 32'h0000_0001;
		end
	end
	// ==========
	// Bus
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("bus answer not after one wait state");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {12'h034, 12'h040, 12'h044}))
		else $error("error response wrong for address");
	// ==========
	// Calibration and pins
	a_cal_length: assert property ($fell(calibration_active) |->
		len_reg + 1 >= CAL_CYCLES && len_reg <= CAL_CYCLES + 1)
		else $error("calibration run length wrong");
	a_clk_frozen: assert property (calibration_active && $past(calibration_active) |->
		$stable(analog_ctrl.output_data_clock))
		else $error("data clock moved during calibration");
	a_edge_follow: assert property ((clk_en && $stable(output_edge_select)) [*6] |->
		analog_ctrl.rising_edge_out == output_edge_select)
		else $error("output edge choice not applied");
	a_swing_follow: assert property ((clk_en && $stable(output_swing_select)) [*6] |->
		analog_ctrl.strong_drive == output_swing_select)
		else $error("drive strength choice not applied");
	a_pd_off: assert property ((full_power_down && !calibration_active) [*8] |->
		!analog_ctrl.i_data_oe && !analog_ctrl.q_data_oe)
		else $error("outputs driven in power down");
	a_q_off: assert property (q_channel_power_down [*8] |-> !analog_ctrl.q_data_oe)
		else $error("q outputs driven while q powered down");
	a_pd_no_cal: assert property ((full_power_down && !calibration_active) [*8] |=>
		!calibration_active)
		else $error("calibration started in power down");
endmodule

bind adc_control_pin_sequencer seq_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) i_seq_ctrl_chk (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.output_edge_select(output_edge_select), .output_swing_select(output_swing_select),
	.full_power_down(full_power_down), .q_channel_power_down(q_channel_power_down),
	.calibration_active(calibration_active), .analog_ctrl(analog_ctrl));

/* verif/host_pin_model.sv */
// Host model: drives the calibrate request pin and watches the status pin.
// Assumes its tasks are entered just after a rising pclk edge.
`timescale 1ns/1ps
module host_pin_model (
	input wire logic	pclk,
	input wire logic	calibration_active,
	output logic		cal_request_pin
);
	// ==========
	// Pin sequences
	task automatic hold(input logic lvl);
		cal_request_pin <= lvl;
	endtask
	task automatic request(input int lo, input int hi);
		cal_request_pin <= 1'h0;
		repeat (lo) @(posedge pclk);
		cal_request_pin <= 1'h1;
		repeat (hi) @(posedge pclk);
		cal_request_pin <= 1'h0;
	endtask
	// Completion comes from the status pin, never from a fixed time
	task automatic await(input logic lvl, input int lim, output int n);
		n = 0;
		while (calibration_active !== lvl && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
endmodule

/* verif/adc_control_pin_sequencer_bench.sv */
// Self-checking bench for the control sequencer with shortened counts.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module adc_control_pin_sequencer_bench;
	localparam int DS = 16;
	localparam int DL = 32;
	localparam int CC = 20;
	localparam int LH = 4;
	localparam int HH = 4;
	logic		pclk = 1'h0;
	logic		presetn = 1'h0;
	logic		clk_en = 1'h1;
	logic		psel = 1'h0;
	logic		penable = 1'h0;
	logic		pwrite = 1'h0;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0000_0000;
	logic [31:0]	prdata, rd;
	logic		pready, pslverr, er, cal_request_pin, calibration_active;
	logic		cal_delay_select = 1'h0;
	logic		delay_pin_floating = 1'h0;
	logic		output_edge_select = 1'h0;
	logic		output_swing_select = 1'h0;
	logic		full_power_down = 1'h0;
	logic		q_channel_power_down = 1'h0;
	adc_ctrl_pkg::analog_ctrl_type	analog_ctrl;
	int		err_count = 0;
	int		checks = 0;
	int		regs [int];
	int		n, lo;
	always #25 pclk = ~pclk;
	adc_control_pin_sequencer #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .CAL_CYCLES(CC),
		.LOW_HOLD(LH), .HIGH_HOLD(HH)) i_adc_control_pin_sequencer (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cal_request_pin(cal_request_pin),
		.cal_delay_select(cal_delay_select), .delay_pin_floating(delay_pin_floating),
		.output_edge_select(output_edge_select), .output_swing_select(output_swing_select),
		.full_power_down(full_power_down), .q_channel_power_down(q_channel_power_down),
		.calibration_active(calibration_active), .analog_ctrl(analog_ctrl));
	host_pin_model i_host_pin_model (.pclk(pclk), .calibration_active(calibration_active),
		.cal_request_pin(cal_request_pin));
	// ==========
	// Helpers
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wcal(input logic lvl, input int lim, input bit must, output int w);
		i_host_pin_model.await(lvl, lim, w);
		if (must && w >= lim) begin
			err_count++;
			close_out();
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int w;
		w = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'h1 && w < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			err_count++;
			close_out();
		end
		@(posedge pclk);
	endtask
	task automatic do_reset(input logic sel, input logic flt, input logic pd, input logic pin);
		presetn <= 1'h0;
		cal_delay_select <= sel;
		delay_pin_floating <= flt;
		full_power_down <= pd;
		i_host_pin_model.hold(pin);
		regs[12'h034] = 32'h0000_0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
	endtask
	// ==========
	// Tests
	initial begin
		n = $urandom(40134);
		for (int k = 0; k < 3; k++) begin
			do_reset(k > 0, 1'h0, 1'h0, 1'h0);
			delay_pin_floating <= (k == 2);
			wcal(1'h1, 200, 1'b1, n);
			lo = (k == 1) ? DL : DS;
			chk("start delay", n >= lo && n <= lo + 10, 1);
			@(posedge pclk);
			chk("cal targets", {analog_ctrl.cal_cores, analog_ctrl.cal_termination}, 3);
			wcal(1'h0, 100, 1'b1, n);
			chk("cal length", n + 3 >= CC && n <= CC + 1, 1);
			chk("dual edge", analog_ctrl.dual_edge, k == 2);
		end
		$display("test power-on done");
		do_reset(1'h0, 1'h0, 1'h0, 1'h1);
		wcal(1'h1, 60, 1'b0, n);
		chk("cal with pin high", n, 60);
		i_host_pin_model.request(LH - 1, HH + 2);
		wcal(1'h1, 30, 1'b0, n);
		chk("short low", n, 30);
		i_host_pin_model.request(LH, HH - 1);
		wcal(1'h1, 30, 1'b0, n);
		chk("short high", n, 30);
		repeat (2) begin
			i_host_pin_model.request(LH + $urandom % 3, HH);
			wcal(1'h1, 10, 1'b1, n);
			wcal(1'h0, 100, 1'b1, n);
		end
		$display("test request pin done");
		do_reset(1'h0, 1'h0, 1'h1, 1'h0);
		wcal(1'h1, 60, 1'b0, n);
		chk("cal in power down", n, 60);
		full_power_down <= 1'h0;
		wcal(1'h1, 60, 1'b1, n);
		chk("released delay", n >= DS && n <= DS + 10, 1);
		full_power_down <= 1'h1;
		wcal(1'h0, 60, 1'b1, n);
		chk("cal not cut", n + 3 >= CC, 1);
		i_host_pin_model.request(LH, HH);
		wcal(1'h1, 30, 1'b0, n);
		chk("request ignored", n, 30);
		chk("powered down", {analog_ctrl.i_enable, analog_ctrl.i_data_oe}, 0);
		full_power_down <= 1'h0;
		repeat (10) @(posedge pclk);
		q_channel_power_down <= 1'h1;
		repeat (8) @(posedge pclk);
		chk("q only", {analog_ctrl.i_data_oe, analog_ctrl.q_data_oe}, 2);
		q_channel_power_down <= 1'h0;
		for (int k = 0; k < 4; k++) begin
			{output_edge_select, output_swing_select} <= 2'(k);
			repeat (8) @(posedge pclk);
			chk("edge", analog_ctrl.rising_edge_out, output_edge_select);
			chk("swing", analog_ctrl.strong_drive, output_swing_select);
		end
		clk_en <= 1'h0;
		output_edge_select <= 1'h0;
		repeat (8) @(posedge pclk);
		chk("frozen edge", analog_ctrl.rising_edge_out, 1'h1);
		clk_en <= 1'h1;
		repeat (8) @(posedge pclk);
		chk("resumed edge", analog_ctrl.rising_edge_out, 1'h0);
		$display("test power down and pins done");
		apb(1'h0, 12'h034, 32'h0000_0000, rd, er);
		chk("des reset", rd, regs[12'h034]);
		lo = $urandom & 32'h0000_3fff;
		apb(1'h1, 12'h034, lo, rd, er);
		regs[12'h034] = lo;
		apb(1'h0, 12'h034, 32'h0000_0000, rd, er);
		chk("des read", rd[15:0], regs[12'h034]);
		apb(1'h0, 12'h100, 32'h0000_0000, rd, er);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 0);
		apb(1'h1, 12'h040, 32'h0000_0002, rd, er);
		apb(1'h1, 12'h034, 32'h0000_8000, rd, er);
		chk("ext dual edge", {analog_ctrl.dual_edge, analog_ctrl.q_enable}, 2);
		apb(1'h1, 12'h034, 32'h0000_0000, rd, er);
		apb(1'h0, 12'h044, 32'h0000_0000, rd, er);
		chk("status idle", rd[2:0], 2);
		apb(1'h1, 12'h040, 32'h0000_0001, rd, er);
		wcal(1'h1, 10, 1'b1, n);
		apb(1'h0, 12'h044, 32'h0000_0000, rd, er);
		chk("status cal", rd[2:0], 3);
		wcal(1'h0, 100, 1'b1, n);
		$display("test registers done");
		close_out();
	end
endmodule
